//--- logic/hbsd_slave.sv
// SPI slave with command decode and fault register readout
`timescale 1ns/1ps
`include "hbsd_map.svh"
module hbsd_slave
    import hbsd_pkg::*;
#(
    parameter logic [7:0] DEVICE_ID = 8'h5A,   // Arbitrary value
    parameter logic [3:0] SW_REV    = 4'h0,
    parameter logic [3:0] MASK_REV  = 4'h0
)(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_sck,
    input  wire logic        i_ss_n,
    input  wire logic        i_si,
    input  wire logic        i_enable_pin,
    input  wire logic        i_disable_pin,
    input  wire logic        i_diag_mode_supply_pin,
    input  wire logic        i_main_supply_ok,
    input  wire hbsd_fault_t i_fault,
    output logic             o_so,
    output logic             o_so_oe,
    output logic [7:0]       o_fault_diagnosis
);
    //======================================================================
    // Pin synchronisers
    //======================================================================
    logic [5:0] meta_reg;     // First stage, read only by second
    logic [5:0] sync_reg;     // Second stage
    logic       sck_d_reg;    // Delayed clock for edge find
    logic       ss_d_reg;     // Delayed select for edge find
    logic       dms_d_reg;    // Delayed supply for edge find

    // Two flops per pin. Reset loads the idle levels: deselected, bridge
    // enabled, both supplies present. Without them a clear or an
    // undervoltage image would flash up in the cycles after reset.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_reg <= 6'h35;
            sync_reg <= 6'h35;
        end
        else
        begin
            meta_reg <= {i_main_supply_ok, i_diag_mode_supply_pin,
                         i_disable_pin, i_enable_pin, i_si, i_ss_n};
            sync_reg <= meta_reg;
        end
    end

    wire logic ss_n  = sync_reg[0];
    wire logic si    = sync_reg[1];
    wire logic en    = sync_reg[2];
    wire logic dis   = sync_reg[3];
    wire logic diag_mode_supply_pin   = sync_reg[4];
    wire logic ub_ok = sync_reg[5];
    logic      sck_meta_reg;  // Clock first stage
    logic      sck_sync_reg;  // Clock second stage

    // Clock synchroniser and edge history
    // Delayed copies start at the reset levels of the synced pins
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sck_meta_reg <= 1'b0;
            sck_sync_reg <= 1'b0;
            sck_d_reg    <= 1'b0;
            ss_d_reg     <= 1'b1;
            dms_d_reg    <= 1'b1;
        end
        else
        begin
            sck_meta_reg <= i_sck;
            sck_sync_reg <= sck_meta_reg;
            sck_d_reg    <= sck_sync_reg;
            ss_d_reg     <= ss_n;
            dms_d_reg    <= diag_mode_supply_pin;
        end
    end

    // Edge pulses; logic held idle while diag supply low
    // Link clock edges count only inside a selected frame
    wire logic spi_on   = diag_mode_supply_pin;
    wire logic sck_fall = spi_on & ~ss_n & sck_d_reg & ~sck_sync_reg;
    wire logic sck_rise = spi_on & ~ss_n & ~sck_d_reg & sck_sync_reg;
    wire logic ss_rise  = spi_on & ~ss_d_reg & ss_n;
    wire logic dms_rise = diag_mode_supply_pin & ~dms_d_reg;

    //======================================================================
    // Frame receive
    //======================================================================
    hbsd_state_t state_reg;     // Frame phase
    logic [4:0]  bit_cnt_reg;   // Falling edges seen
    logic [7:0]  cmd_reg;       // Received command byte
    logic        match_reg;     // Address matched
    logic        prev_frame_error_reg; // Error flag of last frame
    logic [7:0]  tx_reg;        // Output shifter
    logic        so_oe_reg;     // Output driven
    logic [7:0]  fault_diagnosis_reg;
    logic [7:0]  data_byte;     // Answer for decoded command
    wire  logic [1:0] chip_select_code = cmd_reg[7:6];
    wire  logic [4:0] command_code     = cmd_reg[5:1];

    // Select the answer byte; unused codes give FF
    always_comb
    begin
        unique case (command_code)
            `HBSD_CMD_IDENT: data_byte = DEVICE_ID;
            `HBSD_CMD_REV:   data_byte = {SW_REV, MASK_REV};
            `HBSD_CMD_DIAG:  data_byte = fault_diagnosis_reg;
            default:         data_byte = `HBSD_NOFUNC_DATA;
        endcase
    end

    // Only the three read codes are valid
    wire logic cmd_valid = (command_code == `HBSD_CMD_IDENT) ||
                           (command_code == `HBSD_CMD_REV) ||
                           (command_code == `HBSD_CMD_DIAG);
    wire logic frame_ok  = (bit_cnt_reg == `HBSD_FRAME_BITS) && cmd_valid &&
                           (chip_select_code == `HBSD_OWN_ADDR);
    // Diag read completed in a valid, addressed frame
    wire logic diag_read = ss_rise && match_reg && frame_ok &&
                           (command_code == `HBSD_CMD_DIAG);

    // Count edges and shift in on falling clock
    // Select high or a missing diag supply forces the wait state
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg   <= HBSD_IDLE;
            bit_cnt_reg <= 5'h00;
            cmd_reg     <= 8'h00;
            match_reg   <= 1'b0;
        end
        else if (ss_n || !spi_on)
        begin
            state_reg   <= HBSD_IDLE;
            bit_cnt_reg <= 5'h00;
        end
        else if (sck_fall)
        begin
            if (bit_cnt_reg != 5'h1F)
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            unique case (state_reg)
                HBSD_IDLE:
                begin
                    cmd_reg   <= {cmd_reg[6:0], si};
                    match_reg <= 1'b0;
                    state_reg <= HBSD_CMD;
                end
                HBSD_CMD:
                begin
                    cmd_reg <= {cmd_reg[6:0], si};
                    // Address known after the second bit
                    if (bit_cnt_reg == 5'h01)
                        match_reg <= ({cmd_reg[0], si} == `HBSD_OWN_ADDR);
                    if (bit_cnt_reg == 5'h07)
                        state_reg <= HBSD_DATA;
                end
                HBSD_DATA:
                    state_reg <= HBSD_DATA;              // Write data ignored
            endcase
        end
    end

    // Record whether the finished addressed frame was valid
    // Frames for other addresses leave the flag as it was
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            prev_frame_error_reg <= 1'b0;
        else if (ss_rise && match_reg)
            prev_frame_error_reg <= ~frame_ok;
    end

    //======================================================================
    // Serial output
    //======================================================================
    // Load check byte, then answer; shift on rising clock
    // The two address bits go out undriven, so the first driven bit is
    // bit 5 of the check byte
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tx_reg    <= 8'h00;
            so_oe_reg <= 1'b0;
        end
        else if (ss_n || !spi_on)
        begin
            tx_reg    <= {2'h0, `HBSD_CHECK_FIXED, prev_frame_error_reg};
            so_oe_reg <= 1'b0;
        end
        else if (sck_rise && bit_cnt_reg != 5'h00)
        begin
            // Drive only after a matching address
            so_oe_reg <= match_reg && (bit_cnt_reg >= 5'h02) &&
                         (bit_cnt_reg < `HBSD_FRAME_BITS);
            if (bit_cnt_reg == 5'h08)
                tx_reg <= data_byte;
            else
                tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    assign o_so    = tx_reg[7];
    assign o_so_oe = so_oe_reg;

    //======================================================================
    // Fault diagnosis register
    //======================================================================
    logic [3:0] out_saved_reg;      // Output bits kept through undervoltage
    logic [3:0] out_bits_reg;       // Output bits as shown
    logic       enable_bit_reg;     // Live enable state, bit 7
    logic [2:0] event_flags;        // Fault events in register bit order
    logic [3:0] out_codes;          // Output codes in register bit order
    wire  logic [2:0] sticky_bits;  // Heat, derate, clip bits, active low
    wire  logic enabled   = en & ~dis;
    wire  logic level_clr = ~enabled;
    wire  logic event_clr = diag_read | dms_rise;
    // Reset image of the whole register
    localparam logic [7:0] DIAG_RST = `HBSD_DIAG_RESET;

    // Events in the order of bits 6 down to 4
    assign event_flags = {i_fault.overheat_flag,
                          i_fault.thermal_derate_flag,
                          i_fault.current_clip_flag};
    // Second output in the upper pair, first output in the lower
    assign out_codes   = {i_fault.out_b_code,
                          i_fault.out_a_code};

    // One sticky active-low bit per fault event. A level clear holds the
    // bit released; an event clear loses to a fault in the same cycle,
    // so that no fault slips past a read or a supply return.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_sticky
            logic flag_reg;     // Low once the event has been seen

            // Level clear first, then set, then event clear
            always_ff @(posedge i_core_clk or posedge i_rst)
            begin
                if (i_rst)
                    flag_reg <= DIAG_RST[`HBSD_BIT_CLIP + gi];
                else if (level_clr)
                    flag_reg <= 1'b1;
                else if (event_flags[gi])
                    flag_reg <= 1'b0;
                else if (event_clr)
                    flag_reg <= 1'b1;
            end

            assign sticky_bits[gi] = flag_reg;
        end
    endgenerate

    // Output codes stay sticky; an event clear keeps a code seen with it
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            out_saved_reg <= DIAG_RST[3:0];
        else if (level_clr)
            out_saved_reg <= 4'hF;
        else if (event_clr)
            out_saved_reg <= out_codes;
        else
            out_saved_reg <= out_saved_reg & out_codes;
    end

    // Shown output bits: forced to zero in undervoltage, and rebuilt
    // from the kept codes once the main supply is back
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            out_bits_reg <= DIAG_RST[3:0];
        else if (!ub_ok)
            out_bits_reg <= `HBSD_OUT_UV;
        else if (level_clr)
            out_bits_reg <= 4'hF;
        else if (event_clr)
            out_bits_reg <= out_codes;
        else
            out_bits_reg <= out_saved_reg & out_codes;
    end

    // Bit 7 follows the enable and disable pins live
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            enable_bit_reg <= DIAG_RST[`HBSD_BIT_ENABLE];
        else
            enable_bit_reg <= enabled;
    end

    // Register image, read only from the bus side
    assign fault_diagnosis_reg = {enable_bit_reg, sticky_bits,
                                  out_bits_reg};
    assign o_fault_diagnosis   = fault_diagnosis_reg;
endmodule

//--- common/hbsd_map.svh
// Constants of the H-bridge SPI diagnostic slave: codes, fields, resets
//==========================================================================
// Notes on behaviour
// - Address bits 7:6, command 5:1, bit0 ignored
// - Own chip address fixed, unique per select
// - Codes: 00000 ident, 00001 rev, 00100 diag
// - Diag register cleared while disabled or not enabled
// - Diag cleared at select rise after diag read
// - Diag cleared when diag supply returns
// - Main undervoltage forces bits 3:0 to 0000
// - Bits 3:0 restored when main supply returns
// - Check byte: two Z bits, then 10101
// - Check bit0 flags error in previous frame
// - Bit4 low on current limiting
// - Bit5 low on thermal current reduction
// - Bit6 low on overtemperature
// - Bits 1:0 encode first output fault
// - Bits 3:2 encode second output fault
// - All four output bits zero means undervoltage
// - Revision: software upper nibble, maskset lower
// - Revision fields are build constants from zero
// - Id and revision read only, own commands
// - Sample on falling, shift on rising clock
// - Exactly sixteen falling edges per frame
// - Output Z until address matches, else whole frame
// - Unused code answers FF, changes nothing; the code still sets check bit0 of the next frame
`ifndef HBSD_MAP_SVH
`define HBSD_MAP_SVH
`define HBSD_FRAME_BITS   5'h10
`define HBSD_OWN_ADDR     2'h0
`define HBSD_CMD_IDENT    5'h00
`define HBSD_CMD_REV      5'h01
`define HBSD_CMD_DIAG     5'h04
`define HBSD_CHECK_FIXED  5'h15
`define HBSD_DIAG_RESET   8'hFF
`define HBSD_NOFUNC_DATA  8'hFF
`define HBSD_OUT_UV       4'h0
`define HBSD_BIT_CLIP     4
`define HBSD_BIT_DERATE   5
`define HBSD_BIT_HEAT     6
`define HBSD_BIT_ENABLE   7
`endif

//--- common/hbsd_pkg.sv
// Types of the H-bridge SPI diagnostic slave
package hbsd_pkg;
    // Fault inputs from the power stage, active high events
    typedef struct packed {
        logic       current_clip_flag;
        logic       thermal_derate_flag;
        logic       overheat_flag;
        logic [1:0] out_a_code;
        logic [1:0] out_b_code;
    } hbsd_fault_t;
    // Frame decode state
    typedef enum logic [2:0] {
        HBSD_IDLE = 3'b001,
        HBSD_CMD  = 3'b010,
        HBSD_DATA = 3'b100
    } hbsd_state_t;
endpackage

//--- bench/hbsd_slave_assertions.sv
// Concurrent checks on the SPI diagnostic slave ports
`timescale 1ns/1ps
module hbsd_slave_assertions
    import hbsd_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_sck,
    input  wire logic        i_ss_n,
    input  wire logic        i_si,
    input  wire logic        i_enable_pin,
    input  wire logic        i_disable_pin,
    input  wire logic        i_diag_mode_supply_pin,
    input  wire logic        i_main_supply_ok,
    input  wire hbsd_fault_t i_fault,
    input  wire logic        o_so,
    input  wire logic        o_so_oe,
    input  wire logic [7:0]  o_fault_diagnosis
);
    //==========
    // Shorthands
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    wire       run  = i_enable_pin && !i_disable_pin;  // Bridge enabled
    wire       calm = run && i_main_supply_ok && i_fault == 7'h0F;
    wire       idle = run && i_ss_n && i_diag_mode_supply_pin;
    wire [7:0] dg   = o_fault_diagnosis;                // Register view
    //==========
    // Serial side
    oe_idle_a: assert property (i_ss_n [*5] |-> !o_so_oe)
        else $error("SO driven while deselected");
    addr_phase_a: assert property ($fell(i_ss_n) |-> !o_so_oe [*8])
        else $error("SO driven in address phase");
    shift_edge_a: assert property (
        $changed(o_so) && o_so_oe && $past(o_so_oe) |-> $past(i_sck, 2))
        else $error("SO moved away from a rising clock");
    //==========
    // Register side
    bit7_state_a: assert property (run [*6] |-> dg[7])
        else $error("Enable bit low while enabled");
    en_clear_a: assert property (
        (!i_enable_pin && i_main_supply_ok) [*6] |-> dg == 8'h7F)
        else $error("Register not cleared while disabled by enable");
    di_clear_a: assert property (
        (i_disable_pin && i_main_supply_ok) [*6] |-> dg == 8'h7F)
        else $error("Register not cleared while disable high");
    uv_force_a: assert property (!i_main_supply_ok [*6] |-> dg[3:0] == 4'h0)
        else $error("Output bits not forced in undervoltage");
    dms_clear_a: assert property (
        $rose(i_diag_mode_supply_pin) && calm ##1 calm [*6] |-> dg == 8'hFF)
        else $error("Register not cleared on supply return");
    clip_bit_a: assert property (
        idle [*5] ##0 i_fault.current_clip_flag |-> ##[1:4] !dg[4])
        else $error("Clip bit not set");
    heat_bit_a: assert property (
        idle [*5] ##0 i_fault.overheat_flag |-> ##[1:4] !dg[6])
        else $error("Overheat bit not set");
    cover property ($rose(o_so_oe));
    cover property ($fell(dg[4]));
    cover property (!i_main_supply_ok && dg[3:0] == 4'h0);
endmodule
bind hbsd_slave hbsd_slave_assertions u_chk (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_sck(i_sck), .i_ss_n(i_ss_n),
    .i_si(i_si), .i_enable_pin(i_enable_pin), .i_disable_pin(i_disable_pin),
    .i_diag_mode_supply_pin(i_diag_mode_supply_pin),
    .i_main_supply_ok(i_main_supply_ok), .i_fault(i_fault), .o_so(o_so),
    .o_so_oe(o_so_oe), .o_fault_diagnosis(o_fault_diagnosis));

//--- bench/hbsd_spi_master.sv
// Controller model that runs SPI frames into the diagnostic slave
`timescale 1ns/1ps
module hbsd_spi_master (
    output logic      o_sck,
    output logic      o_ss_n,
    output logic      o_si,
    input  wire logic i_so,
    input  wire logic i_so_oe
);
    //==========
    // Idle pins: clock high, deselected
    initial
    begin
        o_sck = 1'h1;
        o_ss_n = 1'h1;
        o_si = 1'h0;
    end
    //==========
    // One frame, MSB first, nfall falling edges (16 is legal)
    task automatic frame(input logic [15:0] tx, input int nfall,
                         output logic [15:0] rx, output logic [15:0] oe);
        rx = 16'h0000;
        oe = 16'h0000;
        o_ss_n <= 1'h0;
        o_si <= tx[15];  // Address first
        #62.5;
        for (int k = 0; k < nfall; k++)  // Edge count
        begin
            o_sck <= 1'h0;  // Slave latches here, we sample SO
            // An undriven line reads as the inverse of its last value
            rx = {rx[14:0], i_so_oe ? i_so : ~i_so};
            oe = {oe[14:0], i_so_oe};
            #62.5;
            o_sck <= 1'h1;
            o_si <= (k < 15) ? tx[14 - k] : ~o_si;
            #62.5;
        end
        o_ss_n <= 1'h1;
        o_si <= ~o_si;  // Released line shows no stale value
        #250;
    endtask
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the SPI diagnostic slave
`timescale 1ns/1ps
module tb_top
    import hbsd_pkg::*;
;
    localparam logic [7:0]  ID_VAL = 8'hC3;  // Arbitrary identifier
    localparam hbsd_fault_t NOF    = 7'h0F;  // No fault pending
    logic        clk, rst, en, dis, diag_mode_supply_pin, ok, sck, ss_n, si, so, so_oe;
    logic        perr;
    hbsd_fault_t flt;
    logic [7:0]  diag, xd;
    logic [15:0] rx, oe;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    hbsd_slave #(.DEVICE_ID(ID_VAL), .SW_REV(4'h3), .MASK_REV(4'hA)) dut (
        .i_core_clk(clk), .i_rst(rst), .i_sck(sck), .i_ss_n(ss_n),
        .i_si(si), .i_enable_pin(en), .i_disable_pin(dis),
        .i_diag_mode_supply_pin(diag_mode_supply_pin), .i_main_supply_ok(ok),
        .i_fault(flt), .o_so(so), .o_so_oe(so_oe), .o_fault_diagnosis(diag));
    hbsd_spi_master mst (.o_sck(sck), .o_ss_n(ss_n), .o_si(si),
        .i_so(so), .i_so_oe(so_oe));
    //==========
    // Helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic rd(input logic [7:0] cmd, input logic pe,
                      input logic [7:0] x);
        mst.frame({cmd, 8'h00}, 16, rx, oe);
        check(oe, 16'h3FFF);
        check({2'h0, rx[13:0]}, {2'h0, 5'h15, pe, x});
    endtask
    task automatic pins(input logic [3:0] v);  // en, dis, dms, ok
        @(posedge clk);
        {en, dis, diag_mode_supply_pin, ok} <= v;
        repeat (8) @(posedge clk);
    endtask
    task automatic inject(input hbsd_fault_t f);
        @(posedge clk);
        flt <= f;
        @(posedge clk);
        flt <= NOF;
        repeat (4) @(posedge clk);
    endtask
    //==========
    // Clock and cycle ceiling
    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            fail_count++;
            close_out();
        end
    end
    //==========
    // Main sequence
    initial
    begin
        {en, dis, diag_mode_supply_pin, ok} = 4'hB;
        flt = NOF;
        rst = 1'h1;
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        repeat (8) @(posedge clk);
        check({8'h00, diag}, 16'h00FF);
        perr = 1'h0;
        for (int c = 0; c < 32; c++)  // Every command code
        begin
            xd = (c == 0) ? ID_VAL : (c == 1) ? 8'h3A : 8'hFF;
            rd({2'h0, c[4:0], c[0]}, perr, xd);
            perr = !(c inside {0, 1, 4});
        end
        rd(8'h01, 1'h1, ID_VAL);
        mst.frame(16'h0000, 15, rx, oe);
        rd(8'h00, 1'h1, ID_VAL);
        mst.frame(16'h0000, 17, rx, oe);
        rd(8'h02, 1'h1, 8'h3A);
        mst.frame(16'h4000, 16, rx, oe);
        check(oe, 16'h0000);
        rd(8'h00, 1'h0, ID_VAL);
        for (int c = 0; c < 3; c++)  // Output fault codes
        begin
            inject({3'h0, c[1:0], c[1:0]});
            rd(8'h08, 1'h0, {4'hF, c[1:0], c[1:0]});
            check({8'h00, diag}, 16'h00FF);
        end
        inject(7'h79);
        rd(8'h08, 1'h0, 8'h86);
        inject(7'h0B);
        pins(4'hA);
        check({8'h00, diag}, 16'h00F0);
        pins(4'hB);
        check({8'h00, diag}, 16'h00FE);
        pins(4'h9);
        pins(4'hB);
        check({8'h00, diag}, 16'h00FF);
        pins(4'h3);
        check({8'h00, diag}, 16'h007F);
        pins(4'hF);
        check({8'h00, diag}, 16'h007F);
        pins(4'hB);
        check({8'h00, diag}, 16'h00FF);
        close_out();
    end
endmodule
